// ==== rtl/nipc_pkg.sv ====
package nipc_pkg;

	// Register word width and address width of the register port.
	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;

	// Register offsets as byte addresses of 16-bit words.
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_STACK  = 5'h02;
	localparam logic [ADDR_W-1:0] OFS_LEVEL0 = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_LEVEL1 = 5'h06;

	// Status and control field positions.
	localparam int POS_ENABLE = 7;
	localparam int POS_EMPTY  = 5;
	localparam int POS_FULL   = 4;
	localparam int POS_MASK   = 0;

	// Values after reset.
	localparam logic [DATA_W-1:0] RST_LEVEL = 16'hffff;
	localparam logic [1:0]        LVL_LOW   = 2'h3;

	// Source count, level registers and virtual stack size.
	localparam int NUM_SRC   = 16;
	localparam int NUM_LREG  = 2;
	localparam int SRC_W     = 4;
	localparam int STK_DEPTH = 4;
	localparam logic [2:0] SP_EMPTY = 3'h0;
	localparam logic [2:0] SP_FULL  = 3'h4;

	// Register port request.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} nipc_reg_req_s;

	// Maskable request presented to the CPU.
	typedef struct packed {
		logic             valid;
		logic [1:0]       level;
		logic [SRC_W-1:0] id;
	} nipc_cpu_irq_s;

endpackage

// ==== rtl/nipc_top.sv ====
// What this block does
// - two-bit level per source, zero highest.
// - levels return to three after reset, shutdown.
// - level registers accessible at any time.
// - reset and NMI bypass, beat maskable requests.
// - at most one request to CPU.
// - higher priority preempts ongoing service when nesting.
// - lower priority waits while nesting.
// - equal levels resolved by vector rank.
// - bypass passes requests by rank, ignoring levels.
// - higher vector address means higher rank.
// - bypass lets any later request preempt.
// - forward when stack empty or level above mask, else hold.
// - compare mask is two bits, minimum priority.
// - acceptance pushes level, advances pointer, loads mask.
// - return from interrupt pops stack LIFO.
// - full and empty flags track stack.
// - works up to low power three only.
// - clearing enable bypasses priority comparison.
// - per-source enable and global enable gate.
// - empty at pointer zero, full at four.
// - not-higher request pends, stack unchanged.
// - disabling controller clears virtual stack.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module nipc_top (
	// Clock and reset.
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	// Register port.
	input  wire nipc_pkg::nipc_reg_req_s regReq,
	output logic [nipc_pkg::DATA_W-1:0]  readData_r,
	// Peripheral interrupt sources.
	input  wire logic [nipc_pkg::NUM_SRC-1:0] srcReq,
	input  wire logic [nipc_pkg::NUM_SRC-1:0] srcEnable,
	// CPU core side.
	input  wire logic                    globalIrqEnable,
	input  wire logic                    nmiReq,
	input  wire logic                    cpuAck,
	input  wire logic                    retiPulse,
	output logic                         cpuNmi_r,
	output nipc_pkg::nipc_cpu_irq_s      cpuIrq_r,
	// Power mode.
	input  wire logic                    deepShutdown
);
	import nipc_pkg::*;
	// All arbitration is combinational from the inputs and registered state, so the request
	// toward the CPU always lags its inputs by exactly one cycle.

	// Level setting registers, eight sources per word.
	logic [DATA_W-1:0] levelReg_r [NUM_LREG];
	// Virtual stack entries and pointer.
	// Entry 0 holds the oldest accept; the pointer addresses the next free entry.
	logic [1:0]        stack_r [STK_DEPTH];
	logic [2:0]        stackPtr_r;
	// Nesting enable bit.
	logic              nestEn_r;
	// Current compare mask and stack flags.
	logic [1:0]        curMask;
	logic              stackEmpty;
	logic              stackFull;
	// Index of the top entry.
	logic [1:0]        topIdx;
	// All levels flattened, source i at bits 2i+1:2i.
	logic [2*NUM_SRC-1:0] levels;
	// Sources that may be forwarded now.
	logic [NUM_SRC-1:0] eligible;
	// Winning candidate: found, level, index.
	// Bit 6 is found, bits 5:4 the level and bits 3:0 the source index.
	logic [SRC_W+2:0]  pick;
	// Push and pop events.
	logic              doPush;
	logic              doPop;
	// Software write that clears the enable bit.
	logic              disableWr;

	// Flattened level view.
	// two bits per source.
	assign levels = {levelReg_r[1], levelReg_r[0]};

	// empty at zero, full at four.
	assign stackEmpty = (stackPtr_r == SP_EMPTY);
	assign stackFull  = (stackPtr_r == SP_FULL);
	assign topIdx     = 2'(stackPtr_r - 3'h1);

	assign curMask = stackEmpty ? LVL_LOW : stack_r[topIdx];

	// Pick the best eligible source; ties go to the higher index.
	// The scan runs from index 0 upward and a later source wins a tie, which
	// gives the higher vector address the higher rank without a second pass.
	// With levels ignored every candidate looks like level 0.
	function automatic logic [SRC_W+2:0] pickSource(input logic [NUM_SRC-1:0] elig,
			input logic [2*NUM_SRC-1:0] lv, input logic useLevel);
		logic             found;
		logic [SRC_W-1:0] id;
		logic [1:0]       best;
		logic [1:0]       lvl;
		found = 1'b0;
		id    = '0;
		best  = LVL_LOW;
		lvl   = 2'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			lvl = useLevel ? lv[2*i +: 2] : 2'h0;
			if (elig[i] && (!found || lvl <= best)) begin
				found = 1'b1;
				id    = SRC_W'(i);
				best  = lvl;
			end
		end
		return {found, best, id};
	endfunction

	// Eligibility of each source for forwarding.
	// A source drops out when it is gated off, when nesting is on and its
	// level does not beat the compare mask, or when the stack has no room left.
	// An empty stack lets every level through, level 3 included.
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			// module enable and global enable gate.
			eligible[i] = srcReq[i] && srcEnable[i] && globalIrqEnable;
			// only levels above the mask pass.
			// equal or lower level stays pending.
			if (nestEn_r && !stackEmpty && (levels[2*i +: 2] >= curMask)) begin
				eligible[i] = 1'b0;
			end
			// A full stack takes no further request.
			if (nestEn_r && stackFull) begin
				eligible[i] = 1'b0;
			end
		end
	end

	assign pick = pickSource(eligible, levels, nestEn_r);

	// Stack events only when nesting is on and awake.
	// The push is taken at the hand-over edge rather than at presentation, so a
	// request that is withdrawn before the CPU takes it leaves no trace on the
	// stack.
	// push at the moment of hand-over.
	assign doPush = nestEn_r && !deepShutdown && cpuAck && cpuIrq_r.valid && !stackFull;
	assign doPop  = nestEn_r && !deepShutdown && retiPulse && !stackEmpty;
	// A status write with the enable bit low clears the stack at that very edge.
	assign disableWr = regReq.wr && (regReq.addr == OFS_STATUS) && !regReq.wdata[POS_ENABLE];

	// Nesting enable bit, cleared by reset and deep shutdown.
	// Only bit 7 of the status word is writable; the flags and the mask are
	// views of the stack and ignore writes.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			nestEn_r <= 1'b0;
		end else if (deepShutdown) begin
			nestEn_r <= 1'b0;
		end else if (regReq.wr && regReq.addr == OFS_STATUS) begin
			nestEn_r <= regReq.wdata[POS_ENABLE];
		end
	end

	// Level setting registers.
	// Software may rewrite a level while its source is in service; the stack
	// keeps the level that was pushed, so a change counts from the next accept.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int r = 0; r < NUM_LREG; r++) begin
				levelReg_r[r] <= RST_LEVEL;
			end
		end else if (deepShutdown) begin
			for (int r = 0; r < NUM_LREG; r++) begin
				levelReg_r[r] <= RST_LEVEL;
			end
		end else if (regReq.wr) begin
			if (regReq.addr == OFS_LEVEL0) begin
				levelReg_r[0] <= regReq.wdata;
			end else if (regReq.addr == OFS_LEVEL1) begin
				levelReg_r[1] <= regReq.wdata;
			end
		end
	end

	// Virtual stack pointer and entries.
	// Clearing wins over a push or a pop in the same cycle: leaving nesting or
	// entering deep shutdown must never leave stale levels behind.
	// An accept and a return in the same cycle keep the depth and only
	// overwrite the top entry with the new level.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stackPtr_r <= SP_EMPTY;
			for (int s = 0; s < STK_DEPTH; s++) begin
				stack_r[s] <= LVL_LOW;
			end
		end else if (deepShutdown || !nestEn_r || disableWr) begin
			stackPtr_r <= SP_EMPTY;
			for (int s = 0; s < STK_DEPTH; s++) begin
				stack_r[s] <= LVL_LOW;
			end
		end else if (doPush && doPop) begin
			// A pop and a push together replace the top entry.
			stack_r[topIdx] <= cpuIrq_r.level;
		end else if (doPush) begin
			stack_r[stackPtr_r[1:0]] <= cpuIrq_r.level;
			stackPtr_r               <= stackPtr_r + 3'h1;
		end else if (doPop) begin
			stack_r[topIdx] <= LVL_LOW;
			stackPtr_r      <= stackPtr_r - 3'h1;
		end
	end

	// Request toward the CPU, one at a time.
	// The request is dropped for the cycle after an accept so that the CPU
	// never sees the old winner again before the new mask has taken effect.
	// NMI and deep shutdown hold every maskable request back.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cpuIrq_r <= '0;
		end else begin
			// re-evaluated every cycle, so higher wins.
			cpuIrq_r.valid <= pick[SRC_W+2] && !nmiReq && !deepShutdown && !cpuAck;
			cpuIrq_r.level <= pick[SRC_W+1:SRC_W];
			cpuIrq_r.id    <= pick[SRC_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cpuNmi_r <= 1'b0;
		end else begin
			cpuNmi_r <= nmiReq;
		end
	end

	// Read data stand only in the cycle after the strobe.
	// Unmapped words and idle cycles return zero, so the read data can be
	// OR-ed with those of other slaves.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			readData_r <= '0;
		end else if (regReq.rd) begin
			if (regReq.addr == OFS_STATUS) begin
				readData_r <= '0;
				readData_r[POS_ENABLE]     <= nestEn_r;
				readData_r[POS_EMPTY]      <= stackEmpty;
				readData_r[POS_FULL]       <= stackFull;
				readData_r[POS_MASK +: 2]  <= curMask;
			end else if (regReq.addr == OFS_STACK) begin
				readData_r <= {8'h00, stack_r[3], stack_r[2], stack_r[1], stack_r[0]};
			end else if (regReq.addr == OFS_LEVEL0) begin
				readData_r <= levelReg_r[0];
			end else if (regReq.addr == OFS_LEVEL1) begin
				readData_r <= levelReg_r[1];
			end else begin
				// Unmapped addresses read as zero.
				readData_r <= '0;
			end
		end else begin
			readData_r <= '0;
		end
	end

	// Checks on the design's own behaviour.
	// They watch only what this block drives. Several leave out cycles in
	// which two events meet, because the stack then follows the clearing or
	// replacing order described above.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	nmi_blocks_irq_a: assert property (
		nmiReq |=> !cpuIrq_r.valid && cpuNmi_r)
		else $error("maskable request forwarded beside an NMI");

	gie_gates_irq_a: assert property (
		!globalIrqEnable |=> !cpuIrq_r.valid)
		else $error("request forwarded with global enable low");

	push_advance_a: assert property (
		doPush && !retiPulse && !disableWr |=>
			stackPtr_r == $past(stackPtr_r) + 3'h1 && curMask == $past(cpuIrq_r.level))
		else $error("push did not advance pointer or load mask");

	pop_retreat_a: assert property (
		doPop && !cpuAck && !disableWr |=> stackPtr_r == $past(stackPtr_r) - 3'h1)
		else $error("return did not pop the stack");

	status_flags_a: assert property (
		regReq.rd && regReq.addr == OFS_STATUS |=>
			readData_r[POS_EMPTY] == ($past(stackPtr_r) == 3'h0)
			&& readData_r[POS_FULL] == ($past(stackPtr_r) == 3'h4))
		else $error("stack flags read back wrong");

	bypass_clears_a: assert property (
		disableWr && !deepShutdown |=> stackPtr_r == 3'h0 ##1 stackPtr_r == 3'h0)
		else $error("disabling left stack entries");

	shutdown_levels_a: assert property (
		deepShutdown |=> levelReg_r[0] == 16'hffff && levelReg_r[1] == 16'hffff
			&& !cpuIrq_r.valid)
		else $error("levels not lowest after deep shutdown");

	mask_compare_a: assert property (
		nestEn_r && $past(nestEn_r) && cpuIrq_r.valid && !stackEmpty
			|-> cpuIrq_r.level < curMask)
		else $error("request forwarded not above mask");

	ack_gap_a: assert property (
		cpuAck && cpuIrq_r.valid |=> !cpuIrq_r.valid)
		else $error("request reissued right after acceptance");

	pointer_range_a: assert property (
		stackPtr_r <= 3'h4)
		else $error("stack pointer beyond full");

	nmi_pass_a: assert property (
		cpuNmi_r == $past(nmiReq))
		else $error("NMI not passed straight through");

	stack_hold_a: assert property (
		nestEn_r && !cpuAck && !retiPulse && !disableWr && !deepShutdown
			|=> stackPtr_r == $past(stackPtr_r))
		else $error("stack moved without an accept or a return");

	shutdown_stack_a: assert property (
		deepShutdown |=> stackEmpty && !nestEn_r)
		else $error("stack or enable survived deep shutdown");

	read_idle_a: assert property (
		!regReq.rd |=> readData_r == 16'h0000)
		else $error("read data outside the read cycle");

	bypass_no_stack_a: assert property (
		!nestEn_r |-> stackEmpty)
		else $error("stack holds entries while bypassed");

	push_entry_a: assert property (
		doPush && !retiPulse && !disableWr |=>
			stack_r[topIdx] == $past(cpuIrq_r.level))
		else $error("pushed level not stored in the top entry");

endmodule

// ==== testbench/nipc_cpu_model.sv ====
`timescale 1ns/1ps

// CPU core stand-in: takes a presented request after a chosen number of cycles.
module nipc_cpu_model (
	// Clock and reset.
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	// Request from the controller and the answer to it.
	input  wire nipc_pkg::nipc_cpu_irq_s cpuIrq,
	input  wire logic                    ackOn,
	input  wire logic [1:0]              slow,
	output logic                         ackPulse_r
);
	import nipc_pkg::*;

	// Cycles the request has been seen so far.
	logic [1:0] seen_r;

	// Pulse the take after slow+1 cycles of a seen request; a one-cycle pulse, never twice in a row.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ackPulse_r <= 1'b0;
			seen_r     <= 2'h0;
		end else if (ackPulse_r) begin
			ackPulse_r <= 1'b0;
			seen_r     <= 2'h0;
		end else if (cpuIrq.valid && ackOn) begin
			ackPulse_r <= (seen_r == slow);
			seen_r     <= seen_r + 2'h1;
		end else begin
			seen_r <= 2'h0;
		end
	end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps

module tb;
	import nipc_pkg::*;

	// One bypass case: inputs beside the expected CPU view.
	typedef struct packed {
		logic [15:0] req;
		logic [15:0] en;
		logic        global_irq_enable;
		logic        nmi;
		logic        expValid;
		logic [3:0]  expId;
	} nipc_row_s;

	logic          sys_clk, resetn, globalIrqEnable, nmiReq, cpuAck, retiPulse;
	logic          cpuNmi_r, deepShutdown, ackOn;
	logic [15:0]   readData_r, srcReq, srcEnable;
	logic [1:0]    slow;
	nipc_reg_req_s regReq;
	nipc_cpu_irq_s cpuIrq_r;
	int            nFail, nTests;
	nipc_row_s     rows [5] = '{
		{16'h0004, 16'hffff, 1'b1, 1'b0, 1'b1, 4'h2},
		{16'h8001, 16'hffff, 1'b1, 1'b0, 1'b1, 4'hf},
		{16'h8001, 16'h7fff, 1'b1, 1'b0, 1'b1, 4'h0},
		{16'h8001, 16'hffff, 1'b0, 1'b0, 1'b0, 4'h0},
		{16'h8001, 16'hffff, 1'b1, 1'b1, 1'b0, 4'h0}};

	nipc_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .regReq(regReq),
		.readData_r(readData_r), .srcReq(srcReq), .srcEnable(srcEnable),
		.globalIrqEnable(globalIrqEnable), .nmiReq(nmiReq), .cpuAck(cpuAck),
		.retiPulse(retiPulse), .cpuNmi_r(cpuNmi_r), .cpuIrq_r(cpuIrq_r),
		.deepShutdown(deepShutdown));
	nipc_cpu_model cpu_u (.sys_clk(sys_clk), .resetn(resetn), .cpuIrq(cpuIrq_r),
		.ackOn(ackOn), .slow(slow), .ackPulse_r(cpuAck));

	// Free-running system clock.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Prints the counts and the verdict, then stops.
	task wrap_up;
		$display("Counts: tests=%0d mismatches=%0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle register write.
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk) regReq.wr <= 1'b0;
	endtask

	// One-cycle register read; data is looked at in the following cycle only.
	task rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge sys_clk) regReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk) regReq.rd <= 1'b0;
		@(negedge sys_clk) chk(readData_r, exp);
	endtask

	// Raises requests and waits, bounded, for the CPU to take the expected one.
	task push(input logic [15:0] req, input logic [3:0] id);
		int i;
		@(posedge sys_clk) srcReq <= req;
		for (i = 0; i < 30 && cpuAck !== 1'b1; i++) @(negedge sys_clk);
		if (i == 30) begin
			nFail++;
			wrap_up;
		end
		chk({12'h0, cpuIrq_r.id}, {12'h0, id});
		@(posedge sys_clk) srcReq <= 16'h0;
		repeat (3) @(posedge sys_clk);
	endtask

	// Main sequence: reset, bypass table, then nesting cases.
	initial begin
		resetn = 1'b0; regReq = '0; srcReq = 16'h0; srcEnable = 16'hffff;
		globalIrqEnable = 1'b0; nmiReq = 1'b0; retiPulse = 1'b0; deepShutdown = 1'b0;
		ackOn = 1'b0; slow = 2'h0; nFail = 0; nTests = 0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(OFS_STATUS, 16'h0023);
		rd(OFS_STACK, 16'h00ff);
		rd(OFS_LEVEL1, RST_LEVEL);
		rd(5'h1e, 16'h0000);
		$display("Test reset values done");
		foreach (rows[k]) begin
			@(posedge sys_clk);
			srcReq <= rows[k].req;
			srcEnable <= rows[k].en;
			globalIrqEnable <= rows[k].global_irq_enable;
			nmiReq <= rows[k].nmi;
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			chk({10'h0, cpuNmi_r, cpuIrq_r.valid, cpuIrq_r.valid ? cpuIrq_r.id : 4'h0}, {10'h0, rows[k].nmi, rows[k].expValid, rows[k].expId});
		end
		$display("Test bypass table done");
		@(posedge sys_clk) nmiReq <= 1'b0;
		ackOn <= 1'b1;
		push(16'h8000, 4'hf);
		push(16'h0001, 4'h0);
		rd(OFS_STATUS, 16'h0023);
		wr(OFS_LEVEL0, 16'hfbd3);
		rd(OFS_LEVEL0, 16'hfbd3);
		wr(OFS_STATUS, 16'h0080);
		push(16'h0020, 4'h5);
		rd(OFS_STATUS, 16'h0082);
		push(16'h0004, 4'h2);
		rd(OFS_STATUS, 16'h0081);
		@(posedge sys_clk) ackOn <= 1'b0;
		srcReq <= 16'h0024;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk) chk({15'h0, cpuIrq_r.valid}, 16'h0);
		rd(OFS_STATUS, 16'h0081);
		@(posedge sys_clk) retiPulse <= 1'b1;
		@(posedge sys_clk) retiPulse <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) chk({9'h0, cpuIrq_r.valid, cpuIrq_r.level, cpuIrq_r.id}, 16'h0052);
		rd(OFS_STATUS, 16'h0082);
		@(posedge sys_clk) srcReq <= 16'h0;
		wr(OFS_STATUS, 16'h0000);
		rd(OFS_STATUS, 16'h0023);
		$display("Test nesting done");
		@(posedge sys_clk) ackOn <= 1'b1;
		slow <= 2'h2;
		wr(OFS_STATUS, 16'h0080);
		push(16'h0009, 4'h3);
		push(16'h0020, 4'h5);
		push(16'h0004, 4'h2);
		push(16'h0002, 4'h1);
		rd(OFS_STATUS, 16'h0090);
		rd(OFS_STACK, 16'h001b);
		$display("Test stack full done");
		@(posedge sys_clk) deepShutdown <= 1'b1;
		@(posedge sys_clk) deepShutdown <= 1'b0;
		rd(OFS_STATUS, 16'h0023);
		rd(OFS_LEVEL0, RST_LEVEL);
		$display("Test deep shutdown done");
		wr(OFS_STATUS, 16'h0080);
		wr(OFS_LEVEL0, 16'h1234);
		@(posedge sys_clk) resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(OFS_STATUS, 16'h0023);
		rd(OFS_LEVEL0, RST_LEVEL);
		$display("Test mid-run reset done");
		wrap_up;
	end
endmodule
